// ===== design/tmr8_top.sv
// 8-bit timer with one compare channel behind an apb slave
`timescale 1ns/1ps
`include "tmr8_params.svh"
module tmr8_top #(
  parameter int PRESC_WIDTH = `TMR8_PRESC_WIDTH
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire tmr8_pkg::tmr8_word_t pwdata,
  output tmr8_pkg::tmr8_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_ack_overflow,
  input wire logic irq_ack_compare,
  output logic irq_overflow,
  output logic irq_compare,
  input wire logic osc_pin_in,
  output logic osc_pin_out,
  output logic wave_output,
  output logic wave_output_en
);
  import tmr8_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [2:0] clock_select_field;
  logic wave_mode_hi, wave_mode_lo;
  logic [1:0] compare_output_mode;
  logic async_clock_select;
  // both 8-bit; the counter steps either way
  logic [7:0] count_value_reg, compare_value_reg;
  logic [7:0] compare_buffer;
  logic overflow_flag, compare_flag;
  logic overflow_irq_enable, compare_irq_enable;
  logic count_down, cmp_block, cmp_pending, wave_reg;
  logic osc_meta, osc_sync, osc_prev;
  // declared early: the read mux already needs it
  logic pwm_mode;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic setup, wr, mapped;
  logic sel_ctrl, sel_count, sel_compare, sel_async, sel_flag, sel_mask;
  logic ctrl_wr, count_wr, compare_wr, async_wr, flag_wr, mask_wr;
  logic [7:0] ctrl_rd, rd_byte;

  // one wait-free access phase: pready follows the setup cycle
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready & pwrite;
  assign sel_ctrl = paddr == `TMR8_OFF_CTRL;
  assign sel_count = paddr == `TMR8_OFF_COUNT;
  assign sel_compare = paddr == `TMR8_OFF_COMPARE;
  assign sel_async = paddr == `TMR8_OFF_ASYNC;
  assign sel_flag = paddr == `TMR8_OFF_FLAG;
  assign sel_mask = paddr == `TMR8_OFF_MASK;
  assign mapped = sel_ctrl | sel_count | sel_compare | sel_async |
                  sel_flag | sel_mask;
  // an unmapped write is dropped; pslverr already marks it
  assign ctrl_wr = wr & sel_ctrl;
  assign count_wr = wr & sel_count;
  assign compare_wr = wr & sel_compare;
  assign async_wr = wr & sel_async;
  assign flag_wr = wr & sel_flag;
  assign mask_wr = wr & sel_mask;

  // read mux; force strobe always reads zero
  assign ctrl_rd = {1'b0, wave_mode_lo, compare_output_mode, wave_mode_hi,
                    clock_select_field};
  assign rd_byte =
    sel_ctrl ? ctrl_rd :
    sel_count ? count_value_reg :
    sel_compare ? (pwm_mode ? compare_buffer : compare_value_reg) :
    sel_async ? {4'h0, async_clock_select, 3'h0} :
    sel_flag ? {6'h00, compare_flag, overflow_flag} :
    sel_mask ? {6'h00, compare_irq_enable, overflow_irq_enable} :
    `TMR8_RST_BYTE;

  // bus answer registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `TMR8_RST_WORD;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= {24'h000000, rd_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock source: oscillator pin sampled into clk_sys, then prescaled
  logic osc_rise, src_tick, timer_tick;

  // the pin passes two flops before the edge detector looks at it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
      osc_pin_out <= 1'b0;
    end else begin
      osc_meta <= osc_pin_in;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
      osc_pin_out <= async_clock_select & ~osc_sync;
    end
  end

  // oscillator sampled in clk_sys, so writes need no domain crossing
  assign osc_rise = osc_sync & ~osc_prev;
  assign src_tick = async_clock_select ? osc_rise : 1'b1;

  tmr8_presc #(
    .WIDTH(PRESC_WIDTH)
  ) u_presc (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .src_tick(src_tick),
    .clock_select_field(clock_select_field),
    .timer_tick(timer_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // counter unit
  tmr8_wave_t wave_mode;
  logic at_max, at_bottom, at_top, cmp_equal, real_match;
  logic count_clear, next_count_down, count_tick;
  logic overflow_event, buffer_load;
  logic [7:0] top_value, next_count;

  assign wave_mode = tmr8_wave_t'({wave_mode_hi, wave_mode_lo});
  assign pwm_mode = (wave_mode == TMR8_WM_PHASE_PWM) |
                    (wave_mode == TMR8_WM_FAST_PWM);
  assign at_max = count_value_reg == `TMR8_MAX;
  assign at_bottom = count_value_reg == `TMR8_BOTTOM;
  assign top_value = (wave_mode == TMR8_WM_CLEAR_ON_MATCH) ?
                     compare_value_reg : `TMR8_MAX;
  assign at_top = count_value_reg == top_value;
  // comparator runs all the time; a recent counter write masks it
  assign cmp_equal = count_value_reg == compare_value_reg;
  assign real_match = timer_tick & cmp_equal & ~cmp_block;
  assign count_clear = (wave_mode == TMR8_WM_CLEAR_ON_MATCH) &
                       real_match & at_top;
  // the counter only moves on system clocks carrying a tick
  assign count_tick = timer_tick & ~count_wr;

  // direction: only phase correct pwm turns round, at max and at bottom
  always_comb begin
    next_count_down = 1'b0;
    if (wave_mode == TMR8_WM_PHASE_PWM) begin
      if (at_max) begin
        next_count_down = 1'b1;
      end else if (at_bottom) begin
        next_count_down = 1'b0;
      end else begin
        next_count_down = count_down;
      end
    end
  end

  // clear, decrement or increment by one
  assign next_count = count_clear ? `TMR8_BOTTOM :
                      next_count_down ? count_value_reg - 8'h01 :
                      count_value_reg + 8'h01;

  // overflow at the max-to-zero step, or at bottom in phase correct pwm
  assign overflow_event = count_tick &
    ((wave_mode == TMR8_WM_PHASE_PWM) ? at_bottom : at_max);
  // buffered compare loads at max, the top of both pwm sequences
  assign buffer_load = timer_tick & pwm_mode & at_max;

  // counter, direction and compare registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_value_reg <= `TMR8_RST_BYTE;
      count_down <= 1'b0;
      compare_value_reg <= `TMR8_RST_BYTE;
      compare_buffer <= `TMR8_RST_BYTE;
    end else begin
      if (count_wr) begin
        count_value_reg <= pwdata[7:0];
      end else if (timer_tick) begin
        count_value_reg <= next_count;
      end
      if (count_tick) begin
        count_down <= next_count_down;
      end
      if (compare_wr) begin
        compare_buffer <= pwdata[7:0];
      end
      if (compare_wr & ~pwm_mode) begin
        compare_value_reg <= pwdata[7:0];
      end else if (buffer_load) begin
        compare_value_reg <= compare_buffer;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: a setting event always beats a clear in the same cycle
  logic overflow_clr, compare_clr, compare_set;

  assign overflow_clr = irq_ack_overflow |
                        (flag_wr & pwdata[`TMR8_OVF_BIT]);
  assign compare_clr = irq_ack_compare |
                       (flag_wr & pwdata[`TMR8_CMP_BIT]);
  assign compare_set = timer_tick & cmp_pending;

  // match pending, write block and flag registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmp_block <= 1'b0;
      cmp_pending <= 1'b0;
      overflow_flag <= 1'b0;
      compare_flag <= 1'b0;
    end else begin
      if (count_wr) begin
        cmp_block <= 1'b1;
      end else if (timer_tick) begin
        cmp_block <= 1'b0;
      end
      if (timer_tick) begin
        cmp_pending <= real_match;
      end
      overflow_flag <= overflow_event |
                       (overflow_flag & ~overflow_clr);
      compare_flag <= compare_set | (compare_flag & ~compare_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // waveform generator
  logic force_cmp, next_wave;
  logic [1:0] act_com;

  assign force_cmp = ctrl_wr & pwdata[`TMR8_FOC_BIT] & ~pwm_mode;
  // a forced compare takes effect at once with the bits written beside it
  assign act_com = force_cmp ? pwdata[`TMR8_COM_MSB:`TMR8_COM_LSB] :
                   compare_output_mode;

  // mode zero of the output field leaves the output alone
  always_comb begin
    next_wave = wave_reg;
    case (wave_mode)
      TMR8_WM_NORMAL, TMR8_WM_CLEAR_ON_MATCH: begin
        if (real_match | force_cmp) begin
          case (act_com)
            2'h1: next_wave = ~wave_reg;
            2'h2: next_wave = 1'b0;
            2'h3: next_wave = 1'b1;
            default: next_wave = wave_reg;
          endcase
        end
      end
      TMR8_WM_FAST_PWM: begin
        // max wins over a match there, so compare at max holds steady
        if (count_tick & at_max & compare_output_mode[1]) begin
          next_wave = ~compare_output_mode[0];
        end else if (real_match & compare_output_mode[1]) begin
          next_wave = compare_output_mode[0];
        end
      end
      TMR8_WM_PHASE_PWM: begin
        // clear while counting up, set while counting down (non-inverted)
        if (real_match & compare_output_mode[1]) begin
          next_wave = compare_output_mode[0] ^ count_down;
        end
      end
      default: next_wave = wave_reg;
    endcase
  end

  // control registers, output and interrupt requests
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clock_select_field <= 3'h0;
      wave_mode_hi <= 1'b0;
      wave_mode_lo <= 1'b0;
      compare_output_mode <= 2'h0;
      async_clock_select <= 1'b0;
      overflow_irq_enable <= 1'b0;
      compare_irq_enable <= 1'b0;
      wave_reg <= 1'b0;
      wave_output <= 1'b0;
      wave_output_en <= 1'b0;
      irq_overflow <= 1'b0;
      irq_compare <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        clock_select_field <= pwdata[`TMR8_CS_MSB:`TMR8_CS_LSB];
        wave_mode_hi <= pwdata[`TMR8_WM_HI_BIT];
        wave_mode_lo <= pwdata[`TMR8_WM_LO_BIT];
        compare_output_mode <= pwdata[`TMR8_COM_MSB:`TMR8_COM_LSB];
      end
      if (async_wr) begin
        async_clock_select <= pwdata[`TMR8_AS_BIT];
      end
      if (mask_wr) begin
        overflow_irq_enable <= pwdata[`TMR8_OVF_BIT];
        compare_irq_enable <= pwdata[`TMR8_CMP_BIT];
      end
      wave_reg <= next_wave;
      wave_output <= next_wave;
      wave_output_en <= compare_output_mode != 2'h0;
      irq_overflow <= overflow_flag & overflow_irq_enable;
      irq_compare <= compare_flag & compare_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_COUNT_WRITE_WINS: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    count_wr |=> count_value_reg == $past(pwdata[7:0]))
    else $error("counter write lost to a count action");

  AST_STOPPED_HOLDS: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (clock_select_field == 3'h0 && !count_wr) |=> $stable(count_value_reg))
    else $error("counter moved with no clock selected");

  AST_NORMAL_WRAP: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (count_tick && wave_mode == TMR8_WM_NORMAL && at_max)
      |=> (count_value_reg == 8'h00) && overflow_flag)
    else $error("normal mode wrap or overflow wrong");

  AST_CTC_CLEAR: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (count_tick && wave_mode == TMR8_WM_CLEAR_ON_MATCH && real_match)
      |=> count_value_reg == 8'h00)
    else $error("clear on match did not clear");

  AST_FLAG_NEXT_TICK: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    real_match |=> cmp_pending)
    else $error("match not held for the next timer tick");

  AST_MATCH_SETS_FLAG: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    real_match ##1 (cmp_pending && timer_tick) |=> compare_flag)
    else $error("compare flag not set on the tick after a match");

  AST_WRITE_BLOCKS: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (count_wr ##1 timer_tick) |=> !cmp_pending)
    else $error("match not blocked after counter write");

  AST_FORCE_NO_FLAG: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (force_cmp && !compare_flag && !cmp_pending) |=> !compare_flag)
    else $error("force strobe set the compare flag");

  AST_W1C_CLEAR: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (compare_clr && !compare_set) |=> !compare_flag)
    else $error("compare flag not cleared");

  AST_COM_ZERO_HOLDS: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (compare_output_mode == 2'h0 && !ctrl_wr) |=> $stable(wave_output))
    else $error("output moved with compare output mode zero");

  AST_PWM_BUFFERED: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (pwm_mode && !buffer_load) |=> $stable(compare_value_reg))
    else $error("compare value changed outside top in pwm mode");
endmodule : tmr8_top

// ===== design/tmr8_params.svh
// constants for the 8-bit timer with one compare channel
// Operation
// - counter and compare value are 8-bit registers; counter counts up or down.
// - internal count, direction, clear, top and bottom signals; step of one.
// - timer clock is the system clock unless async select picks the oscillator.
// - clock select zero stops the timer clock and counting.
// - bottom is 0x00, max is 0xff, top is max or compare by mode.
// - each timer clock clears, increments or decrements the counter per mode.
// - software reads and writes the counter whether or not it runs.
// - a software counter write beats any clear or count in that cycle.
// - two mode bits pick the count sequence; overflow flag set per mode.
// - requests sit in a shared flag register, each maskable in a mask register.
// - comparator matches on equality; compare flag sets on the next timer clock.
// - compare enable lets flag request; acknowledge or write-one clears it.
// - waveform output formed from match, mode bits, max and bottom.
// - compare value double buffered in pwm modes, loaded at top or bottom.
// - software reaches the buffer when buffering is on, else the compare value.
// - force strobe in non-pwm modes acts on output only, no flag, no clear.
// - a counter write blocks a compare match on the next timer clock.
// - waveform output register keeps its value across mode changes.
// - mode 0 counts up, wraps at 0xff, overflow set as count becomes zero.
// - mode 2 clears counter on compare match; compare value is top.
// - compare output mode zero makes no output change at a match.
`ifndef TMR8_PARAMS_SVH
`define TMR8_PARAMS_SVH

// register byte offsets
`define TMR8_OFF_CTRL 8'h00
`define TMR8_OFF_COUNT 8'h04
`define TMR8_OFF_COMPARE 8'h08
`define TMR8_OFF_ASYNC 8'h0c
`define TMR8_OFF_FLAG 8'h10
`define TMR8_OFF_MASK 8'h14

// control register fields
`define TMR8_CS_LSB 0
`define TMR8_CS_MSB 2
`define TMR8_WM_HI_BIT 3
`define TMR8_COM_LSB 4
`define TMR8_COM_MSB 5
`define TMR8_WM_LO_BIT 6
`define TMR8_FOC_BIT 7
// async status, flag and mask fields
`define TMR8_AS_BIT 3
`define TMR8_OVF_BIT 0
`define TMR8_CMP_BIT 1

// reset values
`define TMR8_RST_BYTE 8'h00
`define TMR8_RST_WORD 32'h0000_0000

// counter extremes
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hff

// prescaler: width and divide exponents per clock select code
`define TMR8_PRESC_WIDTH 10
`define TMR8_DIV_SHIFT_CS1 5'h00
`define TMR8_DIV_SHIFT_CS2 5'h03
`define TMR8_DIV_SHIFT_CS3 5'h05
`define TMR8_DIV_SHIFT_CS4 5'h06
`define TMR8_DIV_SHIFT_CS5 5'h07
`define TMR8_DIV_SHIFT_CS6 5'h08
`define TMR8_DIV_SHIFT_CS7 5'h0a

`endif

// ===== design/tmr8_pkg.sv
// types shared by the 8-bit timer files
package tmr8_pkg;
  // counting sequence, in wave mode field order
  typedef enum logic [1:0] {
    TMR8_WM_NORMAL,
    TMR8_WM_PHASE_PWM,
    TMR8_WM_CLEAR_ON_MATCH,
    TMR8_WM_FAST_PWM
  } tmr8_wave_t;

  typedef logic [31:0] tmr8_word_t;
endpackage : tmr8_pkg

// ===== design/tmr8_presc.sv
// prescaler that turns a source tick into the timer tick enable
`timescale 1ns/1ps
`include "tmr8_params.svh"
module tmr8_presc #(
  parameter int WIDTH = `TMR8_PRESC_WIDTH
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic src_tick,
  input wire logic [2:0] clock_select_field,
  output logic timer_tick
);
  import tmr8_pkg::*;

  logic [WIDTH-1:0] div_count;
  logic [WIDTH-1:0] tap_mask;
  logic [4:0] shift;

  // the widest divider must fit the counter
  if (WIDTH < int'(`TMR8_DIV_SHIFT_CS7) || WIDTH > 31) begin : g_bad_width
    $error("tmr8_presc: WIDTH out of range");
  end

  // divide exponent per clock select code
  always_comb begin
    case (clock_select_field)
      3'h1: shift = `TMR8_DIV_SHIFT_CS1;
      3'h2: shift = `TMR8_DIV_SHIFT_CS2;
      3'h3: shift = `TMR8_DIV_SHIFT_CS3;
      3'h4: shift = `TMR8_DIV_SHIFT_CS4;
      3'h5: shift = `TMR8_DIV_SHIFT_CS5;
      3'h6: shift = `TMR8_DIV_SHIFT_CS6;
      3'h7: shift = `TMR8_DIV_SHIFT_CS7;
      default: shift = 5'h00;
    endcase
  end

  // code zero lets no tick through, so the counter stands still
  assign tap_mask = ~({WIDTH{1'b1}} << shift);
  assign timer_tick = src_tick & (clock_select_field != 3'h0) &
                      ((div_count & tap_mask) == tap_mask);

  // free running divider; never reset by software, so phase is arbitrary
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_count <= '0;
    end else if (src_tick) begin
      div_count <= div_count + 1'b1;
    end
  end
endmodule : tmr8_presc

// ===== verification/tb_top.sv
// self-checking bench for the 8-bit timer with one compare channel
`timescale 1ns/1ps
`include "tmr8_params.svh"
module tb_top;
  import tmr8_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  tmr8_word_t pwdata = 32'h0000_0000;
  tmr8_word_t prdata;
  logic pready, pslverr, irq_overflow, irq_compare;
  logic osc_pin_out, wave_output, wave_output_en;
  logic irq_ack_overflow = 1'b0;
  logic irq_ack_compare = 1'b0;
  logic osc_pin_in = 1'b0;
  int fails = 0;
  int check_count = 0;
  tmr8_word_t rdat;
  logic rerr;
  logic [7:0] offs [6];
  logic [7:0] frc [6];
  logic exp_wave [6];

  tmr8_top #(.PRESC_WIDTH(10)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .irq_ack_overflow(irq_ack_overflow), .irq_ack_compare(irq_ack_compare),
    .irq_overflow(irq_overflow), .irq_compare(irq_compare),
    .osc_pin_in(osc_pin_in), .osc_pin_out(osc_pin_out),
    .wave_output(wave_output), .wave_output_en(wave_output_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 50 mhz system clock
  always #10 clk_sys = ~clk_sys;

  // verdict in one place; a hang also ends up here
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // word compare, case equality so unknowns never match
  task automatic chk(input tmr8_word_t got, input tmr8_word_t exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // single-bit compare for flags and pins
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk({31'h0, got}, {31'h0, exp}, what);
  endtask : chk_bit

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_sys);
    end
    if (n == 20) begin
      fails++;
      $display("[FAIL] %0t bus timeout", $time);
      stop_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input tmr8_word_t exp,
                    input string what);
    apb(1'b0, a, 8'h00);
    chk(rdat, exp, what);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole run is far below this bound
  initial begin
    cyc(20000);
    fails++;
    $display("[FAIL] %0t run timeout", $time);
    stop_test();
  end

  // main sequence
  initial begin
    offs = '{`TMR8_OFF_CTRL, `TMR8_OFF_COUNT, `TMR8_OFF_COMPARE,
             `TMR8_OFF_ASYNC, `TMR8_OFF_FLAG, `TMR8_OFF_MASK};
    frc = '{8'hb0, 8'h80, 8'ha0, 8'h90, 8'h90, 8'hb0};
    exp_wave = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    cyc(3);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(offs[i], 32'h0, "reset value");
    end
    apb(1'b0, 8'h18, 8'h00);
    chk_bit(rerr, 1'b1, "unmapped error");
    done("reset");
    // stopped counter stays put but is still accessible
    wr(`TMR8_OFF_COUNT, 8'h5a);
    cyc(10);
    rd(`TMR8_OFF_COUNT, 32'h5a, "stopped count");
    done("stopped");
    // wrap from max sets overflow; flags masked and cleared
    wr(`TMR8_OFF_COUNT, 8'hf0);
    wr(`TMR8_OFF_MASK, 8'h01);
    wr(`TMR8_OFF_CTRL, 8'h01);
    cyc(20);
    wr(`TMR8_OFF_CTRL, 8'h00);
    rd(`TMR8_OFF_FLAG, 32'h3, "overflow flag");
    chk_bit(irq_overflow, 1'b1, "overflow request");
    chk_bit(irq_compare, 1'b0, "masked compare request");
    irq_ack_overflow <= 1'b1;
    cyc(1);
    irq_ack_overflow <= 1'b0;
    wr(`TMR8_OFF_FLAG, 8'h02);
    rd(`TMR8_OFF_FLAG, 32'h0, "flags cleared");
    chk_bit(irq_overflow, 1'b0, "request dropped");
    done("overflow");
    // a counter write hides the match on the next tick only
    wr(`TMR8_OFF_COMPARE, 8'h20);
    wr(`TMR8_OFF_COUNT, 8'h20);
    wr(`TMR8_OFF_CTRL, 8'h01);
    cyc(6);
    wr(`TMR8_OFF_CTRL, 8'h00);
    rd(`TMR8_OFF_FLAG, 32'h0, "blocked match");
    wr(`TMR8_OFF_COUNT, 8'h1e);
    wr(`TMR8_OFF_CTRL, 8'h01);
    cyc(6);
    wr(`TMR8_OFF_CTRL, 8'h00);
    rd(`TMR8_OFF_FLAG, 32'h2, "compare flag");
    wr(`TMR8_OFF_MASK, 8'h02);
    cyc(2);
    chk_bit(irq_compare, 1'b1, "compare request");
    done("match");
    // clear on match keeps the count at or below compare
    wr(`TMR8_OFF_FLAG, 8'h03);
    wr(`TMR8_OFF_COMPARE, 8'h10);
    wr(`TMR8_OFF_COUNT, 8'h00);
    wr(`TMR8_OFF_CTRL, 8'h19);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, `TMR8_OFF_COUNT, 8'h00);
      chk_bit(rdat[7:0] <= 8'h10, 1'b1, "count above top");
    end
    wr(`TMR8_OFF_CTRL, 8'h18);
    chk_bit(wave_output_en, 1'b1, "pin override");
    rd(`TMR8_OFF_FLAG, 32'h2, "no overflow in ctc");
    done("ctc");
    // forced compare in normal mode: output only, per output mode
    wr(`TMR8_OFF_FLAG, 8'h03);
    for (int i = 0; i < 6; i++) begin
      wr(`TMR8_OFF_CTRL, frc[i]);
      cyc(2);
      chk_bit(wave_output, exp_wave[i], "forced output");
    end
    rd(`TMR8_OFF_FLAG, 32'h0, "force sets no flag");
    wr(`TMR8_OFF_CTRL, 8'h78);
    cyc(2);
    chk_bit(wave_output, 1'b1, "output kept on mode change");
    wr(`TMR8_OFF_CTRL, 8'he8);
    cyc(2);
    chk_bit(wave_output, 1'b1, "force ignored in pwm");
    done("force");
    // pwm writes land in the buffer until top is reached
    wr(`TMR8_OFF_COMPARE, 8'h33);
    rd(`TMR8_OFF_COMPARE, 32'h33, "buffer readback");
    wr(`TMR8_OFF_CTRL, 8'h00);
    rd(`TMR8_OFF_COMPARE, 32'h10, "compare not loaded");
    // fast pwm run passes max, where the buffer loads
    wr(`TMR8_OFF_CTRL, 8'h49);
    cyc(300);
    wr(`TMR8_OFF_CTRL, 8'h00);
    rd(`TMR8_OFF_COMPARE, 32'h33, "compare loaded at top");
    // phase correct pwm turns round at max: seven ticks from 0xfd
    wr(`TMR8_OFF_COUNT, 8'hfd);
    wr(`TMR8_OFF_CTRL, 8'h41);
    cyc(4);
    wr(`TMR8_OFF_CTRL, 8'h40);
    rd(`TMR8_OFF_COUNT, 32'hfa, "down count after max");
    done("buffer");
    // oscillator pin clocks the counter when async select is set
    wr(`TMR8_OFF_ASYNC, 8'h08);
    wr(`TMR8_OFF_COUNT, 8'h00);
    wr(`TMR8_OFF_CTRL, 8'h01);
    cyc(6);
    rd(`TMR8_OFF_COUNT, 32'h0, "still oscillator");
    chk_bit(osc_pin_out, 1'b1, "oscillator echo");
    repeat (10) begin
      osc_pin_in <= 1'b1;
      cyc(3);
      osc_pin_in <= 1'b0;
      cyc(3);
    end
    cyc(6);
    rd(`TMR8_OFF_COUNT, 32'h0a, "oscillator ticks");
    done("async");
    stop_test();
  end
endmodule : tb_top
